/* cicr_core.sv */
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Global enable (bit 7) lets every enabled source request a vector; when clear nothing does.
// - Peripheral group enable (bit 6) passes enabled peripheral requests or blocks them all.
// - Bit 5 enables the timer0 overflow interrupt.
// - Bit 4 enables the external pin interrupt.
// - Bit 2 is set on timer0 overflow or by a software write of one, and a software write of zero clears it.
// - Bit 0 reads one while at least one monitored pin has a recorded change.
// - Bit 0 reads zero with no recorded pin change and ignores software writes.
// - Every bit of interrupt_control resets to zero on every reset.
// - Edge select one picks rising edges, zero falling edges, for the external pin flag.
// - Each flag is set by its event regardless of the interrupt_control enable bits; pin change flags only for pins set in pin_en_reg.
// - Bit 0 clears itself only when all per-pin change flags have been cleared.
// - A set flag with its enable and global enable makes the core vector to address 0004h.
module cicr_core #(
    parameter int PINS = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [cicr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer0_overflow,
    input wire logic ext_irq_pin,
    input wire logic [PINS-1:0] port_pins,
    input wire logic peripheral_irq,
    input wire logic core_vector_taken,
    input wire logic core_return,
    output logic vector_request,
    output logic [15:0] vector_address,
    output logic irq
);
    import cicr_pkg::*;

    cicr_bus_state_type bus_state_reg;
    cicr_ctrl_type ctrl_reg;
    logic edge_sel_reg;
    logic [PINS-1:0] pin_en_reg;
    logic [EVT_N-1:0] status_reg;
    logic [EVT_N-1:0] mask_reg;
    logic ext_rise;
    logic ext_fall;
    logic [PINS-1:0] pin_rise;
    logic [PINS-1:0] pin_fall;
    logic [PINS-1:0] pc_flags;
    logic pc_summary;
    logic pc_new;
    logic wr_take;
    logic rd_start;
    logic ext_evt;
    logic any_src;
    logic [EVT_N-1:0] evt_vec;
    logic [PINS-1:0] pc_clear;
    logic [31:0] read_word;
    logic ctrl_wr;
    logic pcf_wr;
    logic stat_wr;

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [4:0] ofs);
        hit = (addr[ADDR_W-1:2] == ofs[4:2]);
    endfunction

    cicr_sync3 #(.W(1)) u_ext_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(ext_irq_pin),
        .level_reg(),
        .rise_reg(ext_rise),
        .fall_reg(ext_fall)
    );

    cicr_sync3 #(.W(PINS)) u_pin_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(port_pins),
        .level_reg(),
        .rise_reg(pin_rise),
        .fall_reg(pin_fall)
    );

    cicr_pin_change #(.PINS(PINS)) u_pin_change (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_enable(pin_en_reg),
        .pin_toggle(pin_rise | pin_fall),
        .clear_mask(pc_clear),
        .flags_reg(pc_flags),
        .summary_reg(pc_summary),
        .change_evt_reg(pc_new)
    );

    // bus: request seen in idle, acknowledged one cycle later, then one
    // dead cycle so a held request is never taken twice
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_state_reg <= BUS_IDLE;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg <= BUS_ACK;
                    end
                end
                BUS_ACK: bus_state_reg <= BUS_DONE;
                BUS_DONE: bus_state_reg <= BUS_IDLE;
                default: bus_state_reg <= BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((bus_state_reg == BUS_IDLE) && (avs_read || avs_write));
        end
    end

    always_comb begin
        wr_take = (bus_state_reg == BUS_ACK) && avs_write && avs_byteenable[0];
        rd_start = (bus_state_reg == BUS_IDLE) && avs_read;
        ctrl_wr = wr_take && hit(avs_address, CTRL_OFS);
        pcf_wr = wr_take && hit(avs_address, PCF_OFS);
        stat_wr = wr_take && hit(avs_address, STAT_OFS);
        ext_evt = edge_sel_reg ? ext_rise : ext_fall;
        evt_vec = '0;
        evt_vec[EVT_T0] = timer0_overflow;
        evt_vec[EVT_EXT] = ext_evt;
        evt_vec[EVT_PC] = pc_new;
        pc_clear = '0;
        if (wr_take && hit(avs_address, PCF_OFS)) begin
            pc_clear = avs_writedata[PINS-1:0];
        end
    end

    // unmapped words read as zero
    always_comb begin
        read_word = 32'h0000_0000;
        if (hit(avs_address, CTRL_OFS)) begin
            read_word[7:0] = ctrl_reg;
        end else if (hit(avs_address, EDGE_OFS)) begin
            read_word[EDGE_BIT] = edge_sel_reg;
        end else if (hit(avs_address, PCF_OFS)) begin
            read_word[PINS-1:0] = pc_flags;
        end else if (hit(avs_address, PCEN_OFS)) begin
            read_word[PINS-1:0] = pin_en_reg;
        end else if (hit(avs_address, STAT_OFS)) begin
            read_word[EVT_N-1:0] = status_reg;
        end else if (hit(avs_address, MASK_OFS)) begin
            read_word[EVT_N-1:0] = mask_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_start) begin
            avs_readdata <= read_word;
        end
    end

    // interrupt_control: software writes first, hardware events last so a
    // set in the clearing cycle wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_reg <= CTRL_RST;
        end else begin
            if (wr_take && hit(avs_address, CTRL_OFS)) begin
                ctrl_reg.global_irq_enable <= avs_writedata[GIE_BIT];
                ctrl_reg.peripheral_group_enable <= avs_writedata[PERIPHERAL_GROUP_ENABLE_BIT];
                ctrl_reg.t0ie <= avs_writedata[T0IE_BIT];
                ctrl_reg.inte <= avs_writedata[INTE_BIT];
                ctrl_reg.pin_change_irq_enable <= avs_writedata[PIN_CHANGE_IRQ_ENABLE_BIT];
                ctrl_reg.t0if <= avs_writedata[T0IF_BIT];
                ctrl_reg.ext_pin_irq_flag <= avs_writedata[EXT_PIN_IRQ_FLAG_BIT];
            end
            // core clears the global enable on entry and sets it on return
            if (core_vector_taken) begin
                ctrl_reg.global_irq_enable <= 1'b0;
            end
            if (core_return) begin
                ctrl_reg.global_irq_enable <= 1'b1;
            end
            if (timer0_overflow) begin
                ctrl_reg.t0if <= 1'b1;
            end
            if (ext_evt) begin
                ctrl_reg.ext_pin_irq_flag <= 1'b1;
            end
            // read-only summary, follows the per-pin flags
            ctrl_reg.pin_change_summary_flag <= pc_summary;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            edge_sel_reg <= EDGE_RST;
            pin_en_reg <= PINS'(PCEN_RST);
            mask_reg <= MASK_RST;
        end else if (wr_take) begin
            if (hit(avs_address, EDGE_OFS)) begin
                edge_sel_reg <= avs_writedata[EDGE_BIT];
            end
            if (hit(avs_address, PCEN_OFS)) begin
                pin_en_reg <= avs_writedata[PINS-1:0];
            end
            if (hit(avs_address, MASK_OFS)) begin
                mask_reg <= avs_writedata[EVT_N-1:0];
            end
        end
    end

    // sticky event status, write one to clear, set beats clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_reg <= STAT_RST;
        end else if (wr_take && hit(avs_address, STAT_OFS)) begin
            status_reg <= (status_reg & ~avs_writedata[EVT_N-1:0]) | evt_vec;
        end else begin
            status_reg <= status_reg | evt_vec;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end

    // peripheral requests pass only through the group enable
    always_comb begin
        any_src = (ctrl_reg.t0ie && ctrl_reg.t0if)
            || (ctrl_reg.inte && ctrl_reg.ext_pin_irq_flag)
            || (ctrl_reg.pin_change_irq_enable && ctrl_reg.pin_change_summary_flag)
            || (ctrl_reg.peripheral_group_enable && peripheral_irq);
    end

    // the request drops as soon as the core takes the vector
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            vector_request <= 1'b0;
            vector_address <= 16'h0000;
        end else begin
            vector_request <= ctrl_reg.global_irq_enable && any_src && !core_vector_taken;
            vector_address <= VECTOR_ADDR;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    gie_block_a: assert property (!ctrl_reg.global_irq_enable |=> !vector_request)
        else $error("vector request while global enable clear");
    taken_drop_a: assert property (core_vector_taken |=> !vector_request)
        else $error("vector request held after vector entry");
    gie_entry_a: assert property (
        (core_vector_taken && !core_return) |=> !ctrl_reg.global_irq_enable)
        else $error("global enable still set after vector entry");
    ret_gie_a: assert property (core_return |=> ctrl_reg.global_irq_enable)
        else $error("global enable not set on return");
    pin_change_irq_enable_vector_a: assert property (
        (ctrl_reg.global_irq_enable && ctrl_reg.pin_change_irq_enable && ctrl_reg.pin_change_summary_flag && !core_vector_taken)
        |=> vector_request)
        else $error("enabled pin change flag did not request vector");
    periph_block_a: assert property (
        (ctrl_reg.global_irq_enable && !ctrl_reg.peripheral_group_enable && peripheral_irq
         && !(ctrl_reg.t0ie && ctrl_reg.t0if) && !(ctrl_reg.inte && ctrl_reg.ext_pin_irq_flag)
         && !(ctrl_reg.pin_change_irq_enable && ctrl_reg.pin_change_summary_flag)) |=> !vector_request)
        else $error("peripheral request passed with group enable clear");
    periph_pass_a: assert property (
        (ctrl_reg.global_irq_enable && ctrl_reg.peripheral_group_enable && peripheral_irq && !core_vector_taken)
        |=> vector_request)
        else $error("peripheral request blocked with group enable set");
    t0_vector_a: assert property (
        (ctrl_reg.global_irq_enable && ctrl_reg.t0ie && ctrl_reg.t0if && !core_vector_taken)
        |=> vector_request)
        else $error("enabled timer0 flag did not request vector");
    ext_vector_a: assert property (
        (ctrl_reg.global_irq_enable && ctrl_reg.inte && ctrl_reg.ext_pin_irq_flag && !core_vector_taken)
        |=> vector_request)
        else $error("enabled external flag did not request vector");
    t0_flag_set_a: assert property (timer0_overflow |=> ctrl_reg.t0if)
        else $error("timer0 flag not set on overflow");
    t0_hold_a: assert property ((ctrl_reg.t0if && !ctrl_wr) |=> ctrl_reg.t0if)
        else $error("timer0 flag dropped without software clear");
    t0_quiet_a: assert property (
        (!ctrl_reg.t0if && !timer0_overflow && !ctrl_wr) |=> !ctrl_reg.t0if)
        else $error("timer0 flag set without overflow");
    pc_summary_a: assert property ((|pc_flags) |=> ctrl_reg.pin_change_summary_flag)
        else $error("summary flag clear with pin change recorded");
    pin_flag_a: assert property (
        (|(pin_en_reg & (pin_rise | pin_fall))) |=> (|pc_flags))
        else $error("enabled pin toggle not recorded");
    pc_clear_a: assert property ((pc_flags == '0) |=> !ctrl_reg.pin_change_summary_flag)
        else $error("summary flag set with no pin change recorded");
    ctrl_reset_a: assert property (
        @(posedge ref_clk) disable iff (1'b0) sys_rst |=> (ctrl_reg == CTRL_RST))
        else $error("interrupt_control not zero after reset");
    ext_sticky_a: assert property ((ctrl_reg.ext_pin_irq_flag && !ctrl_wr) |=> ctrl_reg.ext_pin_irq_flag)
        else $error("external flag dropped without software clear");
    ext_quiet_a: assert property (
        (!ctrl_reg.ext_pin_irq_flag && !ext_evt && !ctrl_wr) |=> !ctrl_reg.ext_pin_irq_flag)
        else $error("external flag set without a selected edge");
    edge_sel_a: assert property (
        ((ext_rise && edge_sel_reg) || (ext_fall && !edge_sel_reg)) |=> ctrl_reg.ext_pin_irq_flag)
        else $error("selected edge did not set external flag");
    ext_status_a: assert property (ext_evt |=> ctrl_reg.ext_pin_irq_flag && status_reg[EVT_EXT])
        else $error("external event did not set its flags");
    t0_status_a: assert property (timer0_overflow |=> status_reg[EVT_T0])
        else $error("overflow did not set its status bit");
    pc_status_a: assert property (pc_new |=> status_reg[EVT_PC])
        else $error("pin change did not set its status bit");
    pin_hold_a: assert property (((|pc_flags) && !pcf_wr) |=> (|pc_flags))
        else $error("pin change flags dropped without software clear");
    vector_addr_a: assert property (
        vector_request |-> $past(ctrl_reg.global_irq_enable) && $past(any_src)
        && vector_address == VECTOR_ADDR)
        else $error("vector request without cause or wrong address");

    // bus handshake, event status and interrupt output
    ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    ack_state_a: assert property (!avs_waitrequest |-> bus_state_reg == BUS_ACK)
        else $error("waitrequest low outside the acknowledge state");
    rdata_hold_a: assert property (!rd_start |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    status_hold_a: assert property ((status_reg[EVT_PC] && !stat_wr) |=> status_reg[EVT_PC])
        else $error("pin change status dropped without software clear");
    irq_on_a: assert property ((|(status_reg & mask_reg)) |=> irq)
        else $error("interrupt output low with unmasked status set");
    irq_off_a: assert property (!(|(status_reg & mask_reg)) |=> !irq)
        else $error("interrupt output high with no unmasked status");

    vector_seen_c: cover property (vector_request ##1 core_vector_taken);
    ext_fall_c: cover property (ext_fall && !edge_sel_reg ##1 ctrl_reg.ext_pin_irq_flag);
    pc_clear_c: cover property (ctrl_reg.pin_change_summary_flag ##[1:20] !ctrl_reg.pin_change_summary_flag);
    bus_write_c: cover property (wr_take && hit(avs_address, CTRL_OFS));
    irq_seen_c: cover property ($rose(irq));
endmodule

/* cicr_pkg.sv */
package cicr_pkg;
    localparam int PINS = 8;
    localparam int ADDR_W = 5;
    localparam int EVT_N = 3;
    // byte addresses of the register words
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] EDGE_OFS = 5'h04;
    localparam logic [4:0] PCF_OFS = 5'h08;
    localparam logic [4:0] PCEN_OFS = 5'h0c;
    localparam logic [4:0] STAT_OFS = 5'h10;
    localparam logic [4:0] MASK_OFS = 5'h14;
    // interrupt_control bit positions
    localparam int GIE_BIT = 7;
    localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
    localparam int T0IE_BIT = 5;
    localparam int INTE_BIT = 4;
    localparam int PIN_CHANGE_IRQ_ENABLE_BIT = 3;
    localparam int T0IF_BIT = 2;
    localparam int EXT_PIN_IRQ_FLAG_BIT = 1;
    localparam int PIN_CHANGE_SUMMARY_FLAG_BIT = 0;
    localparam int EDGE_BIT = 0;
    // event status / mask bit positions
    localparam int EVT_T0 = 0;
    localparam int EVT_EXT = 1;
    localparam int EVT_PC = 2;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic EDGE_RST = 1'b0;
    localparam logic [7:0] PCF_RST = 8'h00;
    localparam logic [7:0] PCEN_RST = 8'h00;
    localparam logic [2:0] STAT_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [15:0] VECTOR_ADDR = 16'h0004;

    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_group_enable;
        logic t0ie;
        logic inte;
        logic pin_change_irq_enable;
        logic t0if;
        logic ext_pin_irq_flag;
        logic pin_change_summary_flag;
    } cicr_ctrl_type;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK = 3'b010,
        BUS_DONE = 3'b100
    } cicr_bus_state_type;
endpackage

/* cicr_sync3.sv */
`timescale 1ns/1ps
module cicr_sync3 #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level_reg,
    output logic [W-1:0] rise_reg,
    output logic [W-1:0] fall_reg
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once the second and third stage agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    level_reg[i] <= 1'b0;
                    rise_reg[i] <= 1'b0;
                    fall_reg[i] <= 1'b0;
                end else begin
                    rise_reg[i] <= (s2_reg[i] == s3_reg[i]) && s3_reg[i] && !level_reg[i];
                    fall_reg[i] <= (s2_reg[i] == s3_reg[i]) && !s3_reg[i] && level_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        level_reg[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
endmodule

/* cicr_pin_change.sv */
`timescale 1ns/1ps
module cicr_pin_change #(
    parameter int PINS = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [PINS-1:0] pin_enable,
    input wire logic [PINS-1:0] pin_toggle,
    input wire logic [PINS-1:0] clear_mask,
    output logic [PINS-1:0] flags_reg,
    output logic summary_reg,
    output logic change_evt_reg
);
    import cicr_pkg::*;
    logic [PINS-1:0] set_vec;
    logic [PINS-1:0] flags_next;

    // a toggle in the clearing cycle survives: set beats clear
    always_comb begin
        set_vec = pin_toggle & pin_enable;
        flags_next = (flags_reg & ~clear_mask) | set_vec;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flags_reg <= PINS'(PCF_RST);
            summary_reg <= 1'b0;
            change_evt_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            summary_reg <= |flags_next;
            change_evt_reg <= |set_vec;
        end
    end
endmodule

/* cicr_far_model.sv */
`timescale 1ns/1ps
module cicr_far_model #(
    parameter int LAT = 2
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ovf_go,
    input wire logic ext_lvl,
    input wire logic [7:0] pins_lvl,
    input wire logic periph_lvl,
    input wire logic accept,
    input wire logic ret_go,
    input wire logic vector_request,
    input wire logic [15:0] vector_address,
    output logic timer0_overflow,
    output logic ext_irq_pin,
    output logic [7:0] port_pins,
    output logic peripheral_irq,
    output logic core_vector_taken,
    output logic core_return,
    output logic [7:0] vec_cnt,
    output logic [15:0] vec_addr
);
    logic [3:0] wait_reg;
    logic take;
    // a busy core lets the request stand LAT cycles before it enters the vector
    assign take = accept && vector_request && !core_vector_taken && wait_reg == LAT;
    always_ff @(posedge ref_clk) begin
        timer0_overflow <= ovf_go && !sys_rst;
        ext_irq_pin <= ext_lvl;
        port_pins <= pins_lvl;
        peripheral_irq <= periph_lvl && !sys_rst;
        core_return <= ret_go && !sys_rst;
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !vector_request || core_vector_taken) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != LAT) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            core_vector_taken <= 1'b0;
            vec_cnt <= 8'h00;
            vec_addr <= 16'h0000;
        end else begin
            core_vector_taken <= take;
            if (take) begin
                vec_cnt <= vec_cnt + 8'h01;
                vec_addr <= vector_address;
            end
        end
    end
endmodule

/* core_interrupt_control_register_tb_top.sv */
`timescale 1ns/1ps
module core_interrupt_control_register_tb_top;
    import cicr_pkg::*;
    typedef struct {logic [4:0] a; logic [31:0] d; logic [31:0] e;} cicr_row_type;
    logic ref_clk = 1'b0, sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_waitrequest, timer0_overflow, ext_irq_pin, peripheral_irq;
    logic core_vector_taken, core_return, vector_request, irq;
    logic [7:0] port_pins, vec_cnt;
    logic [15:0] vector_address, vec_addr;
    logic ovf_go = 1'b0, ext_lvl = 1'b0, periph_lvl = 1'b0, accept = 1'b0, ret_go = 1'b0;
    logic [7:0] pins_lvl = 8'h00;
    int n_fail = 0;
    int n_tests = 0;
    cicr_row_type rows[10] = '{'{CTRL_OFS, 32'hff, 32'hfe}, '{CTRL_OFS, 32'h00, 32'h00},
        '{CTRL_OFS, 32'h01, 32'h00}, '{EDGE_OFS, 32'h1, 32'h1}, '{EDGE_OFS, 32'h0, 32'h0},
        '{PCEN_OFS, 32'ha5, 32'ha5}, '{PCEN_OFS, 32'h00, 32'h00}, '{MASK_OFS, 32'h7, 32'h7},
        '{MASK_OFS, 32'h0, 32'h0}, '{5'h18, 32'hff, 32'h00}};

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    cicr_core cicr_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer0_overflow(timer0_overflow),
        .ext_irq_pin(ext_irq_pin), .port_pins(port_pins), .peripheral_irq(peripheral_irq),
        .core_vector_taken(core_vector_taken), .core_return(core_return),
        .vector_request(vector_request), .vector_address(vector_address), .irq(irq));
    cicr_far_model cicr_far_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .ovf_go(ovf_go),
        .ext_lvl(ext_lvl), .pins_lvl(pins_lvl), .periph_lvl(periph_lvl), .accept(accept),
        .ret_go(ret_go), .vector_request(vector_request), .vector_address(vector_address),
        .timer0_overflow(timer0_overflow), .ext_irq_pin(ext_irq_pin), .port_pins(port_pins),
        .peripheral_irq(peripheral_irq), .core_vector_taken(core_vector_taken),
        .core_return(core_return), .vec_cnt(vec_cnt), .vec_addr(vec_addr));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // values are sampled before this edge's updates land, as the slave sees them
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        end_sim();
    end

    initial begin
        cyc(10);
        sys_rst <= 1'b0;
        rdchk("ctrl reset", CTRL_OFS, 32'h0);
        chk("irq reset", {31'h0, irq}, 32'h0);
        chk("vector address", {16'h0, vector_address}, {16'h0, VECTOR_ADDR});
        $display("test reset done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            rdchk("row readback", rows[i].a, rows[i].e);
        end
        $display("test rows done");
        // timer overflow with every interrupt_control enable off still sets the flag; mask bit 0 set lets irq rise
        bus(1'b1, MASK_OFS, 32'h1);
        cyc(1);
        ovf_go <= 1'b1;
        cyc(1);
        ovf_go <= 1'b0;
        cyc(4);
        rdchk("t0 flag", CTRL_OFS, 32'h04);
        chk("no vector", {31'h0, vector_request}, 32'h0);
        chk("irq set", {31'h0, irq}, 32'h1);
        bus(1'b1, STAT_OFS, 32'h1);
        cyc(2);
        chk("irq clear", {31'h0, irq}, 32'h0);
        accept <= 1'b1;
        bus(1'b1, CTRL_OFS, 32'h84);
        cyc(8);
        chk("t0 disabled", {24'h0, vec_cnt}, 32'h0);
        bus(1'b1, CTRL_OFS, 32'ha4);
        cyc(8);
        chk("t0 vector", {24'h0, vec_cnt}, 32'h1);
        chk("vector taken at", {16'h0, vec_addr}, 32'h0004);
        rdchk("gie cleared", CTRL_OFS, 32'h24);
        bus(1'b1, CTRL_OFS, 32'h20);
        @(posedge ref_clk) ret_go <= 1'b1;
        @(posedge ref_clk) ret_go <= 1'b0;
        cyc(3);
        rdchk("t0 cleared", CTRL_OFS, 32'ha0);
        chk("no second vector", {24'h0, vec_cnt}, 32'h1);
        $display("test timer done");
        bus(1'b1, EDGE_OFS, 32'h1);
        bus(1'b1, CTRL_OFS, 32'h90);
        ext_lvl <= 1'b1;
        cyc(12);
        chk("ext vector", {24'h0, vec_cnt}, 32'h2);
        cyc(10);
        rdchk("ext sticky", CTRL_OFS, 32'h12);
        bus(1'b1, CTRL_OFS, 32'h10);
        bus(1'b1, EDGE_OFS, 32'h0);
        ext_lvl <= 1'b0;
        cyc(10);
        rdchk("falling edge", CTRL_OFS, 32'h12);
        bus(1'b1, CTRL_OFS, 32'h10);
        ext_lvl <= 1'b1;
        cyc(10);
        rdchk("rising ignored", CTRL_OFS, 32'h10);
        $display("test ext pin done");
        bus(1'b1, CTRL_OFS, 32'h80);
        periph_lvl <= 1'b1;
        cyc(8);
        chk("group blocked", {24'h0, vec_cnt}, 32'h2);
        bus(1'b1, CTRL_OFS, 32'hc0);
        cyc(8);
        chk("group passed", {24'h0, vec_cnt}, 32'h3);
        periph_lvl <= 1'b0;
        $display("test peripheral done");
        bus(1'b1, PCEN_OFS, 32'h03);
        bus(1'b1, MASK_OFS, 32'h4);
        pins_lvl <= 8'h03;
        cyc(12);
        rdchk("pin flags", PCF_OFS, 32'h03);
        rdchk("summary set", CTRL_OFS, 32'h41);
        chk("pin irq", {31'h0, irq}, 32'h1);
        bus(1'b1, CTRL_OFS, 32'h40);
        rdchk("summary ro", CTRL_OFS, 32'h41);
        bus(1'b1, PCF_OFS, 32'h01);
        cyc(4);
        rdchk("one left", CTRL_OFS, 32'h41);
        bus(1'b1, PCF_OFS, 32'h02);
        cyc(4);
        rdchk("all cleared", CTRL_OFS, 32'h40);
        bus(1'b1, STAT_OFS, 32'h4);
        cyc(2);
        chk("pin irq clear", {31'h0, irq}, 32'h0);
        $display("test pin change done");
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        rdchk("ctrl rereset", CTRL_OFS, 32'h0);
        rdchk("pcen rereset", PCEN_OFS, 32'h0);
        avs_byteenable <= 4'he;
        bus(1'b1, PCEN_OFS, 32'hff);
        avs_byteenable <= 4'hf;
        rdchk("lane ignored", PCEN_OFS, 32'h0);
        $display("test mid reset done");
        end_sim();
    end
endmodule
